// ---- design/usir_pkg.sv ----
// Package: offsets, field positions and reset values of the status block
package usir_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] USIR_OFS_FRAME_REV = 12'h004;
  localparam logic [11:0] USIR_OFS_STATUS1 = 12'h010;
  localparam logic [11:0] USIR_OFS_MASK1 = 12'h014;
  localparam logic [11:0] USIR_OFS_STATUS2 = 12'h018;
  localparam logic [11:0] USIR_OFS_MASK2 = 12'h01c;
  // ==========================================================
  // Field positions
  localparam int USIR_FRAME_W = 11;
  localparam int USIR_REV_LSB = 16;
  localparam int USIR_S1_SUMMARY = 31;
  localparam int USIR_S1_TX_MBOX = 23;
  localparam int USIR_S1_RX_MBOX = 22;
  localparam int USIR_S1_EMPTY_LSB = 19;
  localparam int USIR_S1_ALERT_LSB = 16;
  localparam int USIR_S1_DMA = 10;
  localparam int USIR_S1_OVERRUN = 9;
  localparam int USIR_S1_UNDERRUN = 8;
  localparam int USIR_S1_EP2_DONE = 3;
  localparam int USIR_S2_FRAME_WR = 21;
  localparam int USIR_S2_BAD_FRAME = 20;
  localparam int USIR_S2_BAD_EP = 19;
  localparam int USIR_S2_BUS_LSB = 16;
  localparam int USIR_S2_OVERSIZE = 7;
  localparam int USIR_S2_EXTRA_PKT = 6;
  localparam int USIR_S2_CORRUPT = 5;
  localparam int USIR_S2_NO_TOKEN = 4;
  localparam int USIR_S2_EXTRA_TOKEN = 3;
  localparam int USIR_S2_NO_DATA = 2;
  localparam int USIR_S2_EXTRA_SOF = 1;
  localparam int USIR_S2_SOF_LOST = 0;
  // ==========================================================
  // Implemented bit masks and reset values
  localparam logic [31:0] USIR_S1_IMPL = 32'h80ff_07ff;
  localparam logic [31:0] USIR_S2_IMPL = 32'h003f_00ff;
  localparam logic [31:0] USIR_RESET_VAL = 32'h0000_0000;
  // Pool alert scale factor
  localparam int USIR_ALERT_SCALE = 4;
  // ==========================================================
  // Endpoint 2 receive modes
  typedef enum logic [1:0] {
    USIR_RM_NORMAL0,
    USIR_RM_NORMAL1,
    USIR_RM_ASSEMBLE,
    USIR_RM_SEPARATE
  } usir_rx_mode_t;
endpackage

// ---- design/usir_regs.sv ----
// Status, mask and frame number registers with read-clear events
`timescale 1ns/1ps
// ==========================================================
// Functional notes
// - Frame number held in bits 10:0; bits 15:11 read zero.
// - Fixed revision code in bits 31:16, unaffected by writes.
// - Tx mailbox full flag sets when read and write addresses match.
// - Rx mailbox full flag sets when read and write addresses match.
// - Reading status one clears its events; reserved bits read zero.
// - Pool empty flags set when a pool has no directories left.
// - Pool alert sets when remaining count equals four times threshold.
// - DMA fault flag sets on internal bus error during DMA.
// - Iso OUT FIFO full mid-transaction sets overrun flag.
// - Iso IN FIFO empty mid-transaction sets underrun flag.
// - Segment-done flags in bits 7..0 per endpoint indication.
// - Endpoint 2 receive-done timing follows its receive mode.
// - Summary flag bit 31 set when unmasked status two bit set.
// - Interrupt when any status one bit and its mask bit set.
// - Reading status two clears all its bits.
// - Frame-written flag sets whenever frame number is updated.
// - Bad SOF, extra SOF and lost SOF flags.
// - Bad endpoint token flag on wrong endpoint number.
// - Resume, reset and suspend bus flags.
// - Endpoint 2 oversize flag when data exceeds max packet.
// - Endpoint 2 extra packet and corrupt flags only when enabled.
// - Endpoint 1 token and data flags only when enabled.
// - Summary is OR of status two ANDed with mask two.
module usir_regs
  import usir_pkg::*;
#(
  parameter logic [15:0] REVISION_CODE = 16'h0a5c, // Arbitrary value
  parameter int POOL_CNT_W = 16,
  parameter int MBOX_ADDR_W = 32
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic frame_wr,
  input wire logic [10:0] frame_value,
  input wire logic [MBOX_ADDR_W-1:0] tx_mbox_rd_addr,
  input wire logic [MBOX_ADDR_W-1:0] tx_mbox_wr_addr,
  input wire logic [MBOX_ADDR_W-1:0] rx_mbox_rd_addr,
  input wire logic [MBOX_ADDR_W-1:0] rx_mbox_wr_addr,
  input wire logic [3*POOL_CNT_W-1:0] pool_left,
  input wire logic [3*POOL_CNT_W-1:0] pool_warn_threshold,
  input wire logic dma_bus_error,
  input wire logic iso_out_fifo_full,
  input wire logic iso_in_fifo_empty,
  input wire logic iso_out_busy,
  input wire logic iso_in_busy,
  input wire logic [7:0] seg_done,
  input wire logic ep2_packet_end,
  input wire logic [1:0] ep2_rx_mode,
  input wire logic bad_sof,
  input wire logic extra_sof_evt,
  input wire logic sof_lost_evt,
  input wire logic bad_ep_token,
  input wire logic [2:0] bus_evt,
  input wire logic ep2_oversize,
  input wire logic ep2_extra_pkt,
  input wire logic ep2_corrupt,
  input wire logic ep2_enable,
  input wire logic ep1_enable,
  input wire logic ep1_no_token,
  input wire logic ep1_extra_token,
  input wire logic ep1_no_data,
  output logic iso_out_discard
);
  // Elaboration checks on parameters
  if (POOL_CNT_W < 3 || POOL_CNT_W > 30) begin : g_bad_pool_w
    $error("POOL_CNT_W out of range");
  end
  if (MBOX_ADDR_W < 1) begin : g_bad_mbox_w
    $error("MBOX_ADDR_W out of range");
  end

  // ==========================================================
  // Register state
  logic [10:0] frame_q;
  logic [31:0] stat1_q;
  logic [31:0] stat1_d;
  logic [31:0] mask1_q;
  logic [31:0] stat2_q;
  logic [31:0] stat2_d;
  logic [31:0] mask2_q;
  logic [31:0] rdata_d;
  logic tx_eq_q;
  logic rx_eq_q;
  logic [2:0] empty_q;
  logic [2:0] alert_q;
  logic ovr_q;

  // ==========================================================
  // Address decode
  wire sel_frame = (reg_addr == USIR_OFS_FRAME_REV);
  wire sel_s1 = (reg_addr == USIR_OFS_STATUS1);
  wire sel_m1 = (reg_addr == USIR_OFS_MASK1);
  wire sel_s2 = (reg_addr == USIR_OFS_STATUS2);
  wire sel_m2 = (reg_addr == USIR_OFS_MASK2);
  wire rd_s1 = reg_rd && sel_s1;
  wire rd_s2 = reg_rd && sel_s2;

  // ==========================================================
  // Event detection
  wire tx_eq = (tx_mbox_rd_addr == tx_mbox_wr_addr);
  wire rx_eq = (rx_mbox_rd_addr == rx_mbox_wr_addr);
  wire tx_full_evt = tx_eq && !tx_eq_q;
  wire rx_full_evt = rx_eq && !rx_eq_q;

  logic [2:0] empty_now;
  logic [2:0] alert_now;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pool
      wire [POOL_CNT_W-1:0] left = pool_left[gi*POOL_CNT_W +: POOL_CNT_W];
      wire [POOL_CNT_W+1:0] warn =
        {2'b00, pool_warn_threshold[gi*POOL_CNT_W +: POOL_CNT_W]} * (POOL_CNT_W+2)'(USIR_ALERT_SCALE);
      assign empty_now[gi] = (left == '0);
      assign alert_now[gi] = ({2'b00, left} == warn);
    end
  endgenerate
  wire [2:0] empty_evt = empty_now & ~empty_q;
  wire [2:0] alert_evt = alert_now & ~alert_q;

  // Overrun: FIFO full during transaction, rest of packet discarded
  wire ovr_evt = iso_out_busy && iso_out_fifo_full && !ovr_q;
  assign iso_out_discard = ovr_q || (iso_out_busy && iso_out_fifo_full);
  wire unr_evt = iso_in_busy && iso_in_fifo_empty;

  // EP2 receive done: normal modes per indication, others at packet end
  wire ep2_normal = (ep2_rx_mode == USIR_RM_NORMAL0) || (ep2_rx_mode == USIR_RM_NORMAL1);
  wire ep2_done = ep2_normal ? seg_done[USIR_S1_EP2_DONE]
                             : (seg_done[USIR_S1_EP2_DONE] && ep2_packet_end);

  // Status two event vector
  logic [31:0] ev2;
  always_comb begin
    ev2 = '0;
    ev2[USIR_S2_FRAME_WR] = frame_wr;
    ev2[USIR_S2_BAD_FRAME] = bad_sof;
    ev2[USIR_S2_EXTRA_SOF] = extra_sof_evt;
    ev2[USIR_S2_SOF_LOST] = sof_lost_evt;
    ev2[USIR_S2_BAD_EP] = bad_ep_token;
    ev2[USIR_S2_BUS_LSB +: 3] = bus_evt;
    ev2[USIR_S2_OVERSIZE] = ep2_oversize;
    ev2[USIR_S2_EXTRA_PKT] = ep2_extra_pkt && ep2_enable;
    ev2[USIR_S2_CORRUPT] = ep2_corrupt && ep2_enable;
    ev2[USIR_S2_NO_TOKEN] = ep1_no_token && ep1_enable;
    ev2[USIR_S2_EXTRA_TOKEN] = ep1_extra_token && ep1_enable;
    ev2[USIR_S2_NO_DATA] = ep1_no_data && ep1_enable;
  end

  // Status one event vector
  logic [31:0] ev1;
  always_comb begin
    ev1 = '0;
    ev1[USIR_S1_TX_MBOX] = tx_full_evt;
    ev1[USIR_S1_RX_MBOX] = rx_full_evt;
    ev1[USIR_S1_EMPTY_LSB +: 3] = empty_evt;
    ev1[USIR_S1_ALERT_LSB +: 3] = alert_evt;
    ev1[USIR_S1_DMA] = dma_bus_error;
    ev1[USIR_S1_OVERRUN] = ovr_evt;
    ev1[USIR_S1_UNDERRUN] = unr_evt;
    ev1[7:0] = seg_done;
    ev1[USIR_S1_EP2_DONE] = ep2_done;
  end

  // ==========================================================
  // Sticky status with read-clear; set wins over clear
  wire summary = |(stat2_q & mask2_q);
  always_comb begin
    stat2_d = ((rd_s2 ? 32'h0000_0000 : stat2_q) | ev2) & USIR_S2_IMPL;
    stat1_d = ((rd_s1 ? 32'h0000_0000 : stat1_q) | ev1) & USIR_S1_IMPL;
    stat1_d[USIR_S1_SUMMARY] = summary;
  end

  // ==========================================================
  // Read data mux
  always_comb begin
    if (sel_frame) begin
      rdata_d = {REVISION_CODE, 5'h00, frame_q};
    end else if (sel_s1) begin
      rdata_d = stat1_q;
    end else if (sel_m1) begin
      rdata_d = mask1_q;
    end else if (sel_s2) begin
      rdata_d = stat2_q;
    end else if (sel_m2) begin
      rdata_d = mask2_q;
    end else begin
      rdata_d = 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_d;
  assign irq = |(stat1_q & mask1_q);

  // ==========================================================
  // Flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      frame_q <= '0;
      stat1_q <= USIR_RESET_VAL;
      stat2_q <= USIR_RESET_VAL;
      mask1_q <= USIR_RESET_VAL;
      mask2_q <= USIR_RESET_VAL;
    end else begin
      if (frame_wr) begin
        frame_q <= frame_value;
      end
      stat1_q <= stat1_d;
      stat2_q <= stat2_d;
      if (reg_wr && sel_m1) begin
        mask1_q <= reg_wdata & USIR_S1_IMPL;
      end
      if (reg_wr && sel_m2) begin
        mask2_q <= reg_wdata & USIR_S2_IMPL;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_eq_q <= 1'b0;
      rx_eq_q <= 1'b0;
      empty_q <= 3'b000;
      alert_q <= 3'b000;
      ovr_q <= 1'b0;
    end else begin
      tx_eq_q <= tx_eq;
      rx_eq_q <= rx_eq;
      empty_q <= empty_now;
      alert_q <= alert_now;
      ovr_q <= iso_out_busy && (ovr_q || iso_out_fifo_full);
    end
  end
endmodule

// ---- verification/usir_props.sv ----
// Concurrent checks on the status block ports
`timescale 1ns/1ps
module usir_props (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic irq,
  input wire logic frame_wr,
  input wire logic dma_bus_error,
  input wire logic iso_out_fifo_full,
  input wire logic iso_out_busy,
  input wire logic [7:0] seg_done,
  input wire logic [2:0] bus_evt,
  input wire logic iso_out_discard
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Properties
  a_frame_resv: assert property (reg_addr == 12'h004 |-> reg_rdata[15:11] == 5'h00)
    else $error("frame reserved bits set");
  a_dma_set: assert property (dma_bus_error ##1 reg_addr == 12'h010 |-> reg_rdata[10])
    else $error("dma fault flag missing");
  a_seg_done: assert property (|seg_done ##1 reg_addr == 12'h010 |->
    ((reg_rdata[7:0] & $past(seg_done)) & 8'hf7) == ($past(seg_done) & 8'hf7))
    else $error("segment done flag missing");
  a_irq_mask: assert property (reg_addr == 12'h014 && reg_rdata == 32'h0 |-> !irq)
    else $error("irq with all sources masked");
  a_fw_set: assert property (frame_wr ##1 reg_addr == 12'h018 |-> reg_rdata[21])
    else $error("frame written flag missing");
  a_bus_flags: assert property (|bus_evt ##1 reg_addr == 12'h018 |->
    (reg_rdata[18:16] & $past(bus_evt)) == $past(bus_evt))
    else $error("bus flag missing");
  a_out_discard: assert property (iso_out_busy && iso_out_fifo_full |-> iso_out_discard)
    else $error("overrun data not discarded");
  a_rdclr_dma: assert property (reg_rd && reg_addr == 12'h010 && reg_rdata[10] && !dma_bus_error
    ##1 reg_addr == 12'h010 |-> !reg_rdata[10])
    else $error("dma flag survived read");
endmodule

// ---- verification/usb_status_interrupt_regs_tb_top.sv ----
// Random bench comparing the status block with a behavioural model
`timescale 1ns/1ps
module usb_status_interrupt_regs_tb_top;
  import usir_pkg::*;
  localparam logic [15:0] REV = 16'h3c21; // Arbitrary value
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic [11:0] reg_addr = 12'h004;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, s1, s2, m1, m2;
  logic irq;
  logic [21:0] ev = 22'h0;
  logic [7:0] seg = 8'h00;
  logic [7:0] mb = 8'h44;
  logic [11:0] pl = 12'h555;
  logic [11:0] th = 12'h000;
  logic [10:0] fr;
  logic [7:0] pc;
  logic ov;
  logic [11:0] tbl [6] = '{12'h004, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h020};
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  always #50 sys_clk = ~sys_clk;
  usir_regs #(.REVISION_CODE(REV), .POOL_CNT_W(4), .MBOX_ADDR_W(2)) DUT (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq(irq), .frame_wr(ev[0]),
    .frame_value(reg_wdata[10:0]), .tx_mbox_rd_addr(mb[1:0]), .tx_mbox_wr_addr(mb[3:2]),
    .rx_mbox_rd_addr(mb[5:4]), .rx_mbox_wr_addr(mb[7:6]), .pool_left(pl),
    .pool_warn_threshold(th), .dma_bus_error(ev[1]), .iso_out_fifo_full(ev[2]),
    .iso_in_fifo_empty(ev[3]), .iso_out_busy(ev[4]), .iso_in_busy(ev[5]), .seg_done(seg),
    .ep2_packet_end(ev[6]), .ep2_rx_mode(reg_wdata[12:11]), .bad_sof(ev[7]),
    .extra_sof_evt(ev[8]), .sof_lost_evt(ev[9]), .bad_ep_token(ev[10]), .bus_evt(ev[21:19]),
    .ep2_oversize(ev[11]), .ep2_extra_pkt(ev[12]), .ep2_corrupt(ev[13]), .ep2_enable(ev[14]),
    .ep1_enable(ev[15]), .ep1_no_token(ev[18]), .ep1_extra_token(ev[17]),
    .ep1_no_data(ev[16]), .iso_out_discard());
  // ==========================================================
  // Behavioural model
  always @(posedge sys_clk or negedge nrst) begin
    logic [7:0] c;
    logic n31;
    if (!nrst) begin
      {s1, s2, m1, m2, fr, pc, ov} = '0;
    end else begin
      c = {mb[1:0] == mb[3:2], mb[5:4] == mb[7:6], pl[11:8] == 4'h0, pl[7:4] == 4'h0,
        pl[3:0] == 4'h0, pl[11:8] == {th[9:8], 2'b00}, pl[7:4] == {th[5:4], 2'b00},
        pl[3:0] == {th[1:0], 2'b00}};
      n31 = |(s2 & m2);
      s1 = {n31, (reg_rd && reg_addr == 12'h010) ? 31'h0 : s1[30:0]};
      s1[23:0] = s1[23:0] | {c & ~pc, 5'h00, ev[1], ev[2] & ev[4] & ~ov, ev[3] & ev[5], seg[7:4],
        reg_wdata[12] ? seg[3] & ev[6] : seg[3], seg[2:0]};
      s2 = ((reg_rd && reg_addr == 12'h018) ? 32'h0 : s2) | {10'h0, ev[0], ev[7], ev[10],
        ev[21:19], 8'h00, ev[11], ev[12] & ev[14], ev[13] & ev[14], ev[18:16] & {3{ev[15]}},
        ev[8], ev[9]};
      pc = c;
      ov = ev[4] && (ov || ev[2]);
      if (ev[0]) fr = reg_wdata[10:0];
      if (reg_wr && reg_addr == 12'h014) m1 = reg_wdata & USIR_S1_IMPL;
      if (reg_wr && reg_addr == 12'h01c) m2 = reg_wdata & USIR_S2_IMPL;
    end
  end
  function automatic logic [31:0] exp_rd(input logic [11:0] a);
    case (a)
      12'h004: exp_rd = {REV, 5'h00, fr};
      12'h010: exp_rd = s1;
      12'h014: exp_rd = m1;
      12'h018: exp_rd = s2;
      12'h01c: exp_rd = m2;
      default: exp_rd = 32'h0;
    endcase
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // Checks, stimulus and timeout
  always @(negedge sys_clk) begin
    if (nrst) begin
      cmp(reg_rdata, exp_rd(reg_addr));
      cmp({31'h0, irq}, {31'h0, |(s1 & m1)});
    end
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(73));
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3000) begin
      @(posedge sys_clk);
      reg_addr <= tbl[$urandom % 6];
      reg_rd <= ($urandom % 3) == 0;
      reg_wr <= ($urandom % 4) == 0;
      reg_wdata <= $urandom;
      ev <= 22'($urandom & $urandom & $urandom);
      seg <= 8'($urandom & $urandom & $urandom);
      mb <= 8'($urandom);
      pl <= 12'($urandom);
      th <= 12'($urandom) & 12'h333;
    end
    @(posedge sys_clk);
    end_of_test();
  end
endmodule
bind usir_regs usir_props u_props (
  .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq(irq), .frame_wr(frame_wr), .dma_bus_error(dma_bus_error),
  .iso_out_fifo_full(iso_out_fifo_full), .iso_out_busy(iso_out_busy), .seg_done(seg_done),
  .bus_evt(bus_evt), .iso_out_discard(iso_out_discard));
